// *** hw/supervisor_regs.svh ***
// constants for the supervisor logic core: counts, timing, offsets, fields, resets
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH
// array and pin counts
`define NUM_IN         28
`define NUM_PT         81
`define NUM_MC         16
`define PT_PER_MC      5
`define NUM_TMR        4
`define NUM_CMP        6
`define NUM_DUAL       5
`define NUM_GATE       2
`define NUM_PINS       7
`define SHARED_PT      80
// clocking: reference, master and divided logic clock
`define REF_CLK_KHZ    20000
`define MCLK_KHZ       8000
`define LCLK_DIV       32
`define LCLK_KHZ       (`MCLK_KHZ / `LCLK_DIV)
`define LCLK_US        (1000 / `LCLK_KHZ)
// comparator filter delays
`define FILT_ON_US     48
`define FILT_OFF_US    12
`define FILT_ON_TICKS  ((`FILT_ON_US + `LCLK_US - 1) / `LCLK_US)
`define FILT_OFF_TICKS ((`FILT_OFF_US + `LCLK_US - 1) / `LCLK_US)
// timer intervals
`define TMR_STEPS      128
`define TMR_LAST_STEP  7'h7F
`define TMR_MIN_US     32
`define TMR_MIN_TICKS  ((`TMR_MIN_US + `LCLK_US - 1) / `LCLK_US)
`define TMR_MAX_MS     1960
`define TMR_MAX_TICKS  (`TMR_MAX_MS * 1000 / `LCLK_US)
// register byte offsets
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_ROUTE      12'h008
`define REG_TMR_BASE   12'h010
`define REG_MC_BASE    12'h040
`define REG_PT_BASE    12'h400
`define REG_PT_END     12'h688
// control register fields
`define CTRL_SLEEP_EN  0
`define CTRL_SLEEP_SRC 1
`define CTRL_PROG      2
`define CTRL_DUAL_IN   4
`define CTRL_FET_MODE  9
`define CTRL_REQ_SEL   12
`define CTRL_FILT_EN   16
// reset values and responses
`define CTRL_RST       32'h00000000
`define ROUTE_RST      28'h6543210
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// *** hw/supervisor_pkg.sv ***
// types shared by the supervisor logic core
package supervisor_pkg;
`include "supervisor_regs.svh"
	typedef enum logic [1:0] {ST_POWERUP, ST_RUN, ST_SLEEP, ST_WAKE} pwr_state_e;
	typedef enum logic [2:0] {K_NONE, K_CTRL, K_STATUS, K_ROUTE, K_TMR, K_MC, K_PTT, K_PTC} reg_kind_e;
	typedef struct packed {logic por_set; logic pt_set; logic pt_rst; logic xor_en;
		logic invert; logic bypass; logic toggle;} mc_cfg_s;
	typedef struct packed {logic [3:0] start_sel; logic [6:0] step;} tmr_cfg_s;
	typedef logic [`NUM_IN-1:0] in_vec_t;
	typedef logic [18:0]        tick_cnt_t;
	typedef struct packed {
		pwr_state_e                      st;
		logic [14:0]                     mclk_acc;
		logic                            mclk_en;
		logic [4:0]                      div;
		logic                            tick;
		logic [13:0]                     raw_s1;
		logic [13:0]                     raw_s2;
		logic [1:0]                      din_r;
		logic [`NUM_DUAL-1:0]            dual_r;
		logic [`NUM_CMP-1:0]             cmp_f;
		logic [`NUM_CMP-1:0][3:0]        cmp_cnt;
		logic [`NUM_MC-1:0]              mc;
		tick_cnt_t [`NUM_TMR-1:0]        tmr_cnt;
		logic [`NUM_TMR-1:0]             tmr_flag;
		logic [31:0]                     ctrl;
		logic [27:0]                     route;
		tmr_cfg_s [`NUM_TMR-1:0]         tmr_cfg;
		mc_cfg_s [`NUM_MC-1:0]           mc_cfg;
		in_vec_t [`NUM_PT-1:0]           pt_t;
		in_vec_t [`NUM_PT-1:0]           pt_c;
		logic                            aw_held;
		logic [11:0]                     aw_addr;
		logic                            w_held;
		logic [31:0]                     w_data;
		logic [3:0]                      w_strb;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            rvalid;
		logic [31:0]                     rdata;
		logic [1:0]                      rresp;
		logic [`NUM_DUAL-1:0]            dual_oe;
		logic [`NUM_GATE-1:0]            gate_out;
		logic [`NUM_GATE-1:0]            gate_oe;
		logic                            scan_pull;
	} state_s;
endpackage

// *** hw/supervisor_core.sv ***
// supervisor logic core: clocks, timers, logic array, sleep control, pins, register slave
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "supervisor_regs.svh"

module supervisor_core
	import supervisor_pkg::*;
#(
	parameter int unsigned TMR_MAX_TICKS = `TMR_MAX_TICKS
)
(
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// axi4-lite write channels
	input  wire logic [11:0]            s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read channels
	input  wire logic [11:0]            s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// dedicated inputs and comparator results
	input  wire logic                   wake_sleep_pin,
	input  wire logic [1:0]             digital_in,
	input  wire logic [`NUM_CMP-1:0]    supply_monitor_input,
	// dual-role open-drain pins
	input  wire logic [`NUM_DUAL-1:0]   dual_pin_in,
	output logic [`NUM_DUAL-1:0]        dual_pin_out,
	output logic [`NUM_DUAL-1:0]        dual_pin_oe,
	// gate drive pins and scan supply
	output logic [`NUM_GATE-1:0]        gate_drive_outputs,
	output logic [`NUM_GATE-1:0]        gate_drive_oe,
	output logic                        scan_port_supply_pull
);

	localparam tick_cnt_t TMR_MAX = tick_cnt_t'(TMR_MAX_TICKS);
	localparam state_s    RST_STATE = '{st: ST_POWERUP, ctrl: `CTRL_RST,
		route: `ROUTE_RST, default: '0};

	state_s                  s;
	state_s                  n;
	in_vec_t                 in_vec;
	logic [`NUM_MC-1:0]      fb;
	logic [`NUM_PT-1:0]      pt;
	logic [`NUM_PINS-1:0]    pin_v;
	logic [15:0]             acc_sum;
	logic                    run;
	logic                    wake;
	logic                    sleep_cond;
	logic                    or_v;
	logic                    xor_v;
	logic                    comb_v;
	logic                    start;
	logic [3:0]              flim;
	tick_cnt_t               tlim;
	logic [31:0]             wr_word;
	reg_kind_e               wkind;
	mc_cfg_s                 mcfg;

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	// product term: some mask bit set, all true-mask bits high, all complement-mask bits low
	function automatic logic pt_eval(input in_vec_t v, input in_vec_t t, input in_vec_t c);
		begin
			return (|t | |c) & ((v & t) == t) & ((~v & c) == c);
		end
	endfunction

	// interval in ticks for a step, linear between the end points
	function automatic tick_cnt_t tmr_ticks(input logic [6:0] step, input tick_cnt_t maxv);
		tick_cnt_t span;
		begin
			span = tick_cnt_t'((maxv - tick_cnt_t'(`TMR_MIN_TICKS)) /
				tick_cnt_t'(`TMR_STEPS - 1));
			if (step == `TMR_LAST_STEP)
				return maxv;
			return tick_cnt_t'(`TMR_MIN_TICKS) + tick_cnt_t'(step) * span;
		end
	endfunction

	// address decode shared by read and write paths
	function automatic reg_kind_e reg_decode(input logic [11:0] a);
		begin
			if (a[1:0] != 2'h0)
				return K_NONE;
			if (a == `REG_CTRL)
				return K_CTRL;
			if (a == `REG_STATUS)
				return K_STATUS;
			if (a == `REG_ROUTE)
				return K_ROUTE;
			if ((a & 12'hFF0) == `REG_TMR_BASE)
				return K_TMR;
			if ((a & 12'hFC0) == `REG_MC_BASE)
				return K_MC;
			if (a >= `REG_PT_BASE && a < `REG_PT_END)
				return a[2] ? K_PTC : K_PTT;
			return K_NONE;
		end
	endfunction

	// product term number from a mask address
	function automatic logic [6:0] pt_index(input logic [11:0] a);
		logic [11:0] off;
		begin
			off = a - `REG_PT_BASE;
			return off[9:3];
		end
	endfunction

	// register read mux
	function automatic logic [31:0] reg_read(input state_s st, input logic [11:0] a);
		logic [31:0] r;
		begin
			r = 32'h00000000;
			unique case (reg_decode(a))
				K_CTRL:   r = st.ctrl;
				K_STATUS: r = {4'h0, st.st, st.cmp_f, st.tmr_flag, st.mc};
				K_ROUTE:  r = {4'h0, st.route};
				K_TMR:    r = {21'h000000, st.tmr_cfg[a[3:2]]};
				K_MC:     r = {25'h0000000, st.mc_cfg[a[5:2]]};
				K_PTT:    r = {4'h0, st.pt_t[pt_index(a)]};
				K_PTC:    r = {4'h0, st.pt_c[pt_index(a)]};
				K_NONE:   r = 32'h00000000;
			endcase
			return r;
		end
	endfunction

	// byte-lane merge for writes
	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] w,
		input logic [3:0] strb);
		logic [31:0] m;
		begin
			m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
			return (old & ~m) | (w & m);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb
	begin
		n = s;
		// fractional master clock enable, then divide by 32 for the logic tick
		acc_sum = {1'b0, s.mclk_acc} + 16'(`MCLK_KHZ);
		if (acc_sum >= 16'(`REF_CLK_KHZ))
		begin
			n.mclk_acc = 15'(acc_sum - 16'(`REF_CLK_KHZ));
			n.mclk_en = 1'b1;
		end
		else
		begin
			n.mclk_acc = acc_sum[14:0];
			n.mclk_en = 1'b0;
		end
		n.tick = 1'b0;
		if (s.mclk_en)
		begin
			n.div = s.div + 5'h01;
			n.tick = (s.div == 5'h1F);
		end

		// two-stage pin synchronisers
		n.raw_s1 = {supply_monitor_input, dual_pin_in, digital_in, wake_sleep_pin};
		n.raw_s2 = s.raw_s1;
		wake = s.raw_s2[0];
		run = (s.st == ST_RUN);

		// array inputs; dual pins set as input replace their macrocell feedback
		fb = s.mc;
		for (int i = 0; i < `NUM_DUAL; i++)
		begin
			if (s.ctrl[`CTRL_DUAL_IN + i])
				fb[i] = s.dual_r[i];
		end
		in_vec = {fb, s.tmr_flag, s.cmp_f, s.din_r};
		for (int p = 0; p < `NUM_PT; p++)
			pt[p] = pt_eval(in_vec, s.pt_t[p], s.pt_c[p]);

		// macrocells
		for (int i = 0; i < `NUM_MC; i++)
		begin
			mcfg = s.mc_cfg[i];
			or_v = |pt[`PT_PER_MC*i+1 +: 4] | (~mcfg.xor_en & pt[`PT_PER_MC*i]);
			xor_v = mcfg.xor_en & pt[`PT_PER_MC*i];
			comb_v = or_v ^ xor_v ^ mcfg.invert;
			if (!run)
				n.mc[i] = mcfg.por_set;
			else
			begin
				if (mcfg.bypass)
					n.mc[i] = comb_v;
				else if (s.tick)
					n.mc[i] = mcfg.toggle ? (s.mc[i] ^ comb_v) : comb_v;
				if (mcfg.pt_rst & pt[`SHARED_PT])
					n.mc[i] = 1'b0;
				else if (mcfg.pt_set & pt[`SHARED_PT])
					n.mc[i] = 1'b1;
			end
		end

		// digital inputs on the master clock, ignored outside normal operation
		if (!run)
		begin
			n.din_r = 2'h0;
			n.dual_r = '0;
		end
		else if (s.mclk_en)
		begin
			n.din_r = s.raw_s2[2:1];
			n.dual_r = s.raw_s2[7:3] & s.ctrl[`CTRL_DUAL_IN +: `NUM_DUAL];
		end

		// comparator filters on the logic tick
		for (int c = 0; c < `NUM_CMP; c++)
		begin
			flim = s.ctrl[`CTRL_FILT_EN + c] ? 4'(`FILT_ON_TICKS) : 4'(`FILT_OFF_TICKS);
			if (!run)
			begin
				n.cmp_f[c] = 1'b0;
				n.cmp_cnt[c] = 4'h0;
			end
			else if (s.tick)
			begin
				if (s.raw_s2[8+c] == s.cmp_f[c])
					n.cmp_cnt[c] = 4'h0;
				else if (s.cmp_cnt[c] + 4'h1 >= flim)
				begin
					n.cmp_f[c] = s.raw_s2[8+c];
					n.cmp_cnt[c] = 4'h0;
				end
				else
					n.cmp_cnt[c] = s.cmp_cnt[c] + 4'h1;
			end
		end

		// timers run while their start macrocell is high
		for (int t = 0; t < `NUM_TMR; t++)
		begin
			start = s.mc[s.tmr_cfg[t].start_sel];
			tlim = tmr_ticks(s.tmr_cfg[t].step, TMR_MAX);
			if (!run || !start)
			begin
				n.tmr_cnt[t] = '0;
				n.tmr_flag[t] = 1'b0;
			end
			else if (s.tick && !s.tmr_flag[t])
			begin
				n.tmr_cnt[t] = s.tmr_cnt[t] + 19'h00001;
				if (s.tmr_cnt[t] + 19'h00001 >= tlim)
					n.tmr_flag[t] = 1'b1;
			end
		end

		// sleep control
		sleep_cond = s.ctrl[`CTRL_SLEEP_EN] & ~wake &
			(~s.ctrl[`CTRL_SLEEP_SRC] | ~s.mc[s.ctrl[`CTRL_REQ_SEL +: 4]]);
		unique case (s.st)
			ST_POWERUP: n.st = sleep_cond ? ST_SLEEP : ST_RUN;
			ST_RUN:     n.st = sleep_cond ? ST_SLEEP : ST_RUN;
			ST_SLEEP:   n.st = wake ? ST_WAKE : ST_SLEEP;
			ST_WAKE:    n.st = ST_POWERUP;
		endcase
		n.scan_pull = (n.st == ST_SLEEP);

		// output pins, each routed from a selected macrocell
		for (int p = 0; p < `NUM_PINS; p++)
			pin_v[p] = s.mc[s.route[4*p +: 4]];
		for (int i = 0; i < `NUM_DUAL; i++)
			n.dual_oe[i] = run & ~s.ctrl[`CTRL_DUAL_IN + i] & ~pin_v[i];
		for (int g = 0; g < `NUM_GATE; g++)
		begin
			if (s.ctrl[`CTRL_FET_MODE + g])
			begin
				n.gate_oe[g] = run & ~s.ctrl[`CTRL_PROG];
				n.gate_out[g] = pin_v[`NUM_DUAL+g];
			end
			else
			begin
				n.gate_oe[g] = run & ~s.ctrl[`CTRL_PROG] & ~pin_v[`NUM_DUAL+g];
				n.gate_out[g] = 1'b0;
			end
		end

		// axi4-lite write: hold address and data, commit when both present
		if (s.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			n.aw_held = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			n.w_held = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		wkind = reg_decode(s.aw_addr);
		wr_word = strb_merge(reg_read(s, s.aw_addr), s.w_data, s.w_strb);
		if (s.aw_held && s.w_held && !s.bvalid)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = (wkind == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			unique case (wkind)
				K_CTRL:   n.ctrl = wr_word;
				K_ROUTE:  n.route = wr_word[27:0];
				K_TMR:    n.tmr_cfg[s.aw_addr[3:2]] = tmr_cfg_s'(wr_word[10:0]);
				K_MC:     n.mc_cfg[s.aw_addr[5:2]] = mc_cfg_s'(wr_word[6:0]);
				K_PTT:    n.pt_t[pt_index(s.aw_addr)] = wr_word[27:0];
				K_PTC:    n.pt_c[pt_index(s.aw_addr)] = wr_word[27:0];
				K_STATUS: n.bresp = `RESP_OKAY;
				K_NONE:   n.bresp = `RESP_SLVERR;
			endcase
		end

		// axi4-lite read: one cycle to data
		if (s.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			n.rvalid = 1'b1;
			n.rdata = reg_read(s, s_axi_araddr);
			n.rresp = (reg_decode(s_axi_araddr) == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			s <= RST_STATE;
		else
			s <= n;
	end

	// bus handshakes and registered outputs
	assign s_axi_awready = ~s.aw_held & ~s.bvalid;
	assign s_axi_wready = ~s.w_held & ~s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = ~s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign dual_pin_out = '0; // open drain only pulls low
	assign dual_pin_oe = s.dual_oe;
	assign gate_drive_outputs = s.gate_out;
	assign gate_drive_oe = s.gate_oe;
	assign scan_port_supply_pull = s.scan_pull;

endmodule

// *** tb/supervisor_far_side.sv ***
// far-side model: board pins, pull resistors and supply rails
`timescale 1ns/100ps
`include "supervisor_regs.svh"
module supervisor_far_side
(
	// design pin controls
	input  wire logic [`NUM_DUAL-1:0] dual_pin_oe,
	input  wire logic [`NUM_GATE-1:0] gate_drive_outputs,
	input  wire logic [`NUM_GATE-1:0] gate_drive_oe,
	input  wire logic                 scan_port_supply_pull,
	// board stimulus
	input  wire logic [`NUM_DUAL-1:0] ext_pull_low,
	input  wire logic [`NUM_CMP-1:0]  rails_good,
	// resolved levels
	output logic      [`NUM_DUAL-1:0] dual_pin_in,
	output logic      [`NUM_CMP-1:0]  supply_monitor_input,
	output logic      [`NUM_GATE-1:0] fet_gate,
	output logic                      scan_supply_open
);
	// wired-and pins with pull-ups
	assign dual_pin_in = ~(dual_pin_oe | ext_pull_low);
	// undriven gates bleed to ground
	assign fet_gate = gate_drive_oe & gate_drive_outputs;
	// comparators follow the rails
	assign supply_monitor_input = rails_good;
	// supply pin left open, only the internal pull acts
	assign scan_supply_open = ~scan_port_supply_pull;
endmodule

// *** tb/supervisor_checker_properties.sv ***
// port assertions for the supervisor core
`timescale 1ns/100ps
`include "supervisor_regs.svh"
module supervisor_checker
#(
	parameter int unsigned TMR_MAX_TICKS = 200
)
(
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst_n,
	// bus handshakes
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [31:0]          s_axi_rdata,
	// pins
	input wire logic                 wake_sleep_pin,
	input wire logic [`NUM_DUAL-1:0] dual_pin_out,
	input wire logic [`NUM_DUAL-1:0] dual_pin_oe,
	input wire logic [`NUM_GATE-1:0] gate_drive_oe,
	input wire logic                 scan_port_supply_pull
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	// handshake and wake-pin steps
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wake_low4;
		!wake_sleep_pin [*4];
	endsequence
	////////////////////////////////////////////////////////////
	// pin and sleep behaviour
	AST_SLEEP_FLOAT: assert property (scan_port_supply_pull [*2] |-> !dual_pin_oe && !gate_drive_oe)
		else $error("pin driven in sleep");
	AST_DUAL_OD: assert property (dual_pin_out == '0)
		else $error("dual pin drives high");
	AST_AWAKE: assert property (wake_sleep_pin [*8] |-> !scan_port_supply_pull)
		else $error("asleep with wake high");
	AST_WAKE_ONLY: assert property (wake_low4 ##0 scan_port_supply_pull |=> scan_port_supply_pull)
		else $error("left sleep with wake low");
	AST_RST_QUIET: assert property ($rose(rst_n) |-> !dual_pin_oe && !gate_drive_oe && !scan_port_supply_pull)
		else $error("pins active at power-up");
	// bus behaviour
	AST_RD_LAT: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WR_LAT: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule
bind supervisor_core supervisor_checker #(.TMR_MAX_TICKS(TMR_MAX_TICKS)) chk_u
(
	.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .wake_sleep_pin, .dual_pin_out, .dual_pin_oe, .gate_drive_oe,
	.scan_port_supply_pull
);

// *** tb/tb_top.sv ***
// self-checking bench for the supervisor core
`timescale 1ns/100ps
`include "supervisor_regs.svh"
module tb_top;
	logic        ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, wake_sleep_pin, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, scan_port_supply_pull, scan_supply_open;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, digital_in, gate_drive_outputs, gate_drive_oe, fet_gate;
	logic [4:0]  dual_pin_in, dual_pin_out, dual_pin_oe, ext_pull_low;
	logic [5:0]  supply_monitor_input, rails_good;
	int          num_errors, samples_checked, seed;
	int unsigned exp_reg [int];

	// design and far side
	supervisor_core #(.TMR_MAX_TICKS(200)) dut_u (.ref_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .wake_sleep_pin, .digital_in, .supply_monitor_input, .dual_pin_in,
		.dual_pin_out, .dual_pin_oe, .gate_drive_outputs, .gate_drive_oe, .scan_port_supply_pull);
	supervisor_far_side far_u (.dual_pin_oe, .gate_drive_outputs, .gate_drive_oe,
		.scan_port_supply_pull, .ext_pull_low, .rails_good, .dual_pin_in,
		.supply_monitor_input, .fet_gate, .scan_supply_open);

	// 20 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// bus write, checked against the register model
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, bv, pa, pw;
		int   n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			bv = !pa && !pw && s_axi_bvalid;
			if (bv)
				chk("bresp", exp_reg.exists(a) ? `RESP_OKAY : `RESP_SLVERR, s_axi_bresp);
			@(posedge ref_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			n++;
		end
		while (!bv && n < 60);
		chk("bvalid", 1, bv);
		if (exp_reg.exists(a) && a != `REG_STATUS)
			exp_reg[a] = d;
	endtask
	// bus read, rready held high; data taken while it stands before the handshake edge
	task automatic rd(input logic [11:0] a, input logic [31:0] m);
		logic ta, rv, pa;
		int   n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		pa = 1'b1;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			ta = pa && s_axi_arready;
			rv = !pa && s_axi_rvalid;
			if (rv)
			begin
				chk("rdata", exp_reg.exists(a) ? exp_reg[a] & m : 32'h0, s_axi_rdata & m);
				chk("rresp", exp_reg.exists(a) ? `RESP_OKAY : `RESP_SLVERR, s_axi_rresp);
			end
			@(posedge ref_clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			pa = pa && !ta;
			n++;
		end
		while (!rv && n < 60);
		chk("rvalid", 1, rv);
	endtask
	// bounded wait on the scan supply pull
	task automatic wait_pull(input logic v);
		int n;
		n = 0;
		while (scan_port_supply_pull !== v && n < 120)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("scan pull", v, scan_port_supply_pull);
		@(posedge ref_clk);
	endtask
	// verdict
	task automatic end_sim;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		seed = 94;
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, digital_in, ext_pull_low, rails_good} = '0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		s_axi_wstrb = 4'hF;
		wake_sleep_pin = 1'b1;
		exp_reg[`REG_CTRL] = `CTRL_RST;
		exp_reg[`REG_STATUS] = 32'h04000000;
		exp_reg[`REG_ROUTE] = {4'h0, `ROUTE_RST};
		exp_reg[12'h428] = 0;
		for (int i = 0; i < `NUM_MC; i++)
			exp_reg[`REG_MC_BASE + 4 * i] = 0;
		for (int i = 0; i < `NUM_TMR; i++)
			exp_reg[`REG_TMR_BASE + 4 * i] = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(`REG_CTRL, 32'h003FFFF7);
		rd(`REG_ROUTE, 32'h0FFFFFFF);
		rd(`REG_STATUS, 32'h0C000000);
		wr(`REG_STATUS, 32'hFFFFFFFF);
		wr(12'h00C, 32'h0000FFFF);
		rd(12'h00C, 32'hFFFFFFFF);
		for (int t = 0; t < `NUM_TMR; t++)
		begin
			digital_in <= 2'($random(seed));
			wr(`REG_TMR_BASE + 12'(4 * t), $random(seed));
			rd(`REG_TMR_BASE + 12'(4 * t), 32'h000007FF);
		end
		$display("register test done");
		wake_sleep_pin <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk("pull unset", 0, scan_port_supply_pull);
		wake_sleep_pin <= 1'b1;
		wr(`REG_CTRL, 32'h1);
		repeat (40) @(posedge ref_clk);
		chk("pull awake", 0, scan_port_supply_pull);
		wake_sleep_pin <= 1'b0;
		rails_good <= 6'($random(seed));
		wait_pull(1);
		// pin enables trail the state by one edge, so look a half cycle later
		@(negedge ref_clk);
		chk("dual oe", 0, dual_pin_oe);
		chk("gate oe", 0, gate_drive_oe);
		chk("scan supply", 0, scan_supply_open);
		@(posedge ref_clk);
		exp_reg[`REG_STATUS] = 32'h08000000;
		rd(`REG_STATUS, 32'h0C000000);
		wake_sleep_pin <= 1'b1;
		wait_pull(0);
		repeat (4) @(posedge ref_clk);
		exp_reg[`REG_STATUS] = 32'h04000000;
		rd(`REG_STATUS, 32'h0C000000);
		rd(`REG_CTRL, 32'h003FFFF7);
		$display("pin sleep test done");
		wr(`REG_MC_BASE, 32'h6);
		wr(`REG_CTRL, 32'h3);
		wake_sleep_pin <= 1'b0;
		repeat (60) @(posedge ref_clk);
		chk("pull request high", 0, scan_port_supply_pull);
		wr(`REG_MC_BASE, 32'h0);
		wait_pull(1);
		wake_sleep_pin <= 1'b1;
		wait_pull(0);
		$display("logic sleep test done");
		wr(`REG_CTRL, 32'h600);
		wr(`REG_MC_BASE + 12'h14, 32'h6);
		repeat (8) @(posedge ref_clk);
		chk("gate oe", 3, gate_drive_oe);
		chk("fet gate", 1, fet_gate);
		wr(`REG_CTRL, 32'h604);
		repeat (4) @(posedge ref_clk);
		chk("gate prog", 0, gate_drive_oe);
		$display("gate test done");
		wr(`REG_CTRL, 32'h10);
		wr(`REG_MC_BASE + 12'h4, 32'h2);
		wr(12'h428, 32'h1000);
		for (int v = 0; v < 2; v++)
		begin
			ext_pull_low <= 5'(v);
			repeat (10) @(posedge ref_clk);
			chk("dual oe input", 0, dual_pin_oe[0]);
			exp_reg[`REG_STATUS] = 32'h04000000 | 32'(2 * (1 - v));
			rd(`REG_STATUS, 32'h0C000002);
		end
		$display("dual pin test done");
		// timer 0 started by macrocell 1, which follows dual pin 0; shortest step is 8 ticks
		wr(`REG_TMR_BASE, 32'h00000080);
		ext_pull_low <= 5'h00;
		repeat (480) @(posedge ref_clk);
		exp_reg[`REG_STATUS] = 32'h04000000;
		rd(`REG_STATUS, 32'h0C010000);
		repeat (200) @(posedge ref_clk);
		// filters long settled: comparators show the rails
		exp_reg[`REG_STATUS] = 32'h04010000 | (32'(rails_good) << 20);
		rd(`REG_STATUS, 32'h0FF10000);
		$display("timer test done");
		end_sim;
	end
	// watchdog
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		end_sim;
	end
endmodule
